// [verilog/pdl_pkg.sv]
package pdl_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] DEV_CTL_STAT_ADDR = 8'hC8;
    localparam logic [7:0] LINK_CAP_ADDR = 8'hCC;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;

    // ************************************************************
    // device control / status word at C8
    // ************************************************************
    localparam int REP_EN_LSB = 0;
    localparam int ERR_FLAG_LSB = 16;
    localparam int AUX_PWR_BIT = 20;
    localparam int TXN_PEND_BIT = 21;
    localparam int CTL_BYTE = 0;
    localparam int STAT_BYTE = 2;
    localparam logic [3:0] REP_EN_RST = 4'h0;
    localparam logic [3:0] ERR_FLAG_RST = 4'h0;
    localparam logic AUX_PWR_RST = 1'b1;
    localparam logic TXN_PEND_VAL = 1'b0;

    // ************************************************************
    // link capabilities word at CC
    // ************************************************************
    localparam int SPEED_LSB = 0;
    localparam int WIDTH_LSB = 4;
    localparam int ASPM_LSB = 10;
    localparam int L0S_LSB = 12;
    localparam int L1_LSB = 15;
    localparam int CLKPM_BIT = 18;
    localparam int SDN_BIT = 19;
    localparam int DLL_BIT = 20;
    localparam int BW_BIT = 21;
    localparam int PORT_LSB = 24;
    localparam logic [3:0] SPEED_2G5 = 4'h1;
    localparam logic [3:0] SPEED_5G0 = 4'h2;
    localparam logic [5:0] WIDTH_X1 = 6'h01;
    localparam logic [1:0] ASPM_RST = 2'h3;
    localparam logic [2:0] L0S_RST = 3'h3;
    localparam logic [2:0] L1_RST = 3'h5;
    localparam logic DLL_VAL = 1'b0;

    // error event pulses, one bit per class
    typedef struct packed {
        logic ur;
        logic fat;
        logic nf;
        logic cor;
    } pdl_err_t;

    // overridable capability defaults from the loader
    typedef struct packed {
        logic [7:0] port_num;
        logic clk_pm;
        logic [2:0] l1_lat;
        logic [2:0] l0s_lat;
        logic [1:0] aspm;
    } pdl_cap_t;

endpackage : pdl_pkg

// [verilog/pdl_regs.sv]
module pdl_regs #(
    parameter logic [7:0] PORT_INDEX = 8'h00,
    parameter logic UPSTREAM = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [pdl_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [pdl_pkg::DAT_W-1:0] dat_i,
    output logic [pdl_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    // error detection and power status
    input wire pdl_pkg::pdl_err_t err_ev_i,
    input wire logic aux_pwr_i,
    // capability loader (smbus / eeprom)
    input wire logic ldr_we_i,
    input wire pdl_pkg::pdl_cap_t ldr_cap_i,
    // gated error reports
    output pdl_pkg::pdl_err_t err_report_o
);

    // ************************************************************
    // helpers
    // ************************************************************

    // word-aligned address match
    function automatic logic hit(input logic [pdl_pkg::ADR_W-1:0] adr,
                                 input logic [pdl_pkg::ADR_W-1:0] off);
        hit = (adr[pdl_pkg::ADR_W-1:2] == off[pdl_pkg::ADR_W-1:2]);
    endfunction : hit

    // reset defaults; port number and clk_pm depend on the port's position, latencies and aspm are fixed
    function automatic pdl_pkg::pdl_cap_t cap_default();
        pdl_pkg::pdl_cap_t c;
        c.port_num = PORT_INDEX;
        c.clk_pm = UPSTREAM;
        c.l1_lat = pdl_pkg::L1_RST;
        c.l0s_lat = pdl_pkg::L0S_RST;
        c.aspm = pdl_pkg::ASPM_RST;
        return c;
    endfunction : cap_default

    // ************************************************************
    // state
    // ************************************************************
    logic ack_reg, ack_next;
    logic [pdl_pkg::DAT_W-1:0] rdat_reg, rdat_next;
    logic [3:0] en_reg, en_next;
    logic [3:0] flag_reg, flag_next;
    logic aux_reg, aux_next;
    pdl_pkg::pdl_cap_t cap_reg, cap_next;
    pdl_pkg::pdl_err_t rep_reg, rep_next;

    logic req;
    logic wr_take;
    logic [3:0] ev_vec;
    logic [3:0] clr_vec;
    logic [pdl_pkg::DAT_W-1:0] stat_word;
    logic [pdl_pkg::DAT_W-1:0] cap_word;

    assign req = cyc_i & stb_i;
    // a write lands on the edge where ack is seen, as the master expects
    assign wr_take = req & we_i & ack_reg;
    assign ev_vec = err_ev_i;

    // ************************************************************
    // read words
    // ************************************************************

    // status/control word; reserved bits and pending bit read zero
    always_comb begin
        stat_word = '0;
        stat_word[pdl_pkg::REP_EN_LSB +: 4] = en_reg;
        stat_word[pdl_pkg::ERR_FLAG_LSB +: 4] = flag_reg;
        stat_word[pdl_pkg::AUX_PWR_BIT] = aux_reg;
        stat_word[pdl_pkg::TXN_PEND_BIT] = pdl_pkg::TXN_PEND_VAL;
    end

    // link capabilities; fixed fields are constants, port-type bits from UPSTREAM
    always_comb begin
        cap_word = '0;
        cap_word[pdl_pkg::SPEED_LSB +: 4] = pdl_pkg::SPEED_5G0;
        cap_word[pdl_pkg::WIDTH_LSB +: 6] = pdl_pkg::WIDTH_X1;
        cap_word[pdl_pkg::ASPM_LSB +: 2] = cap_reg.aspm;
        cap_word[pdl_pkg::L0S_LSB +: 3] = cap_reg.l0s_lat;
        cap_word[pdl_pkg::L1_LSB +: 3] = cap_reg.l1_lat;
        cap_word[pdl_pkg::CLKPM_BIT] = cap_reg.clk_pm;
        cap_word[pdl_pkg::SDN_BIT] = ~UPSTREAM;
        cap_word[pdl_pkg::DLL_BIT] = pdl_pkg::DLL_VAL;
        cap_word[pdl_pkg::BW_BIT] = ~UPSTREAM;
        cap_word[pdl_pkg::PORT_LSB +: 8] = cap_reg.port_num;
    end

    // ************************************************************
    // wishbone slave
    // ************************************************************

    // ack one cycle after the request, dropped the cycle after;
    // unmapped addresses are acked and read zero rather than hanging the bus
    always_comb begin
        ack_next = req & ~ack_reg;
        rdat_next = rdat_reg;
        if (ack_next && !we_i) begin
            if (hit(adr_i, pdl_pkg::DEV_CTL_STAT_ADDR)) begin
                rdat_next = stat_word;
            end else if (hit(adr_i, pdl_pkg::LINK_CAP_ADDR)) begin
                rdat_next = cap_word;
            end else begin
                rdat_next = '0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = rdat_reg;

    // ************************************************************
    // control and status
    // ************************************************************

    // w1c from byte lane 2; a set pulse in the clearing cycle survives
    always_comb begin
        clr_vec = '0;
        en_next = en_reg;
        if (wr_take && hit(adr_i, pdl_pkg::DEV_CTL_STAT_ADDR)) begin
            if (sel_i[pdl_pkg::STAT_BYTE]) begin
                clr_vec = dat_i[pdl_pkg::ERR_FLAG_LSB +: 4];
            end
            if (sel_i[pdl_pkg::CTL_BYTE]) begin
                en_next = dat_i[pdl_pkg::REP_EN_LSB +: 4];
            end
        end
        // logging ignores the enables on purpose
        flag_next = (flag_reg & ~clr_vec) | ev_vec;
        rep_next = ev_vec & en_reg;
        aux_next = aux_pwr_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg <= pdl_pkg::REP_EN_RST;
            flag_reg <= pdl_pkg::ERR_FLAG_RST;
            rep_reg <= '0;
            aux_reg <= pdl_pkg::AUX_PWR_RST;
        end else begin
            en_reg <= en_next;
            flag_reg <= flag_next;
            rep_reg <= rep_next;
            aux_reg <= aux_next;
        end
    end

    assign err_report_o = rep_reg;

    // ************************************************************
    // capability defaults and loader override
    // ************************************************************

    // loader writes are taken whole; software cannot touch these fields
    always_comb begin
        cap_next = cap_reg;
        if (ldr_we_i) begin
            cap_next = ldr_cap_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_reg <= cap_default();
        end else begin
            cap_reg <= cap_next;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    // one clock domain; reset masks all but the reset-value checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // read strobes while ack stands; dat_o then holds the word taken an edge earlier
    logic rd_stat;
    logic rd_cap;
    assign rd_stat = ack_reg & ~we_i & hit(adr_i, pdl_pkg::DEV_CTL_STAT_ADDR);
    assign rd_cap = ack_reg & ~we_i & hit(adr_i, pdl_pkg::LINK_CAP_ADDR);
    // a read that decodes to neither word
    logic rd_none;
    assign rd_none = ack_reg & ~we_i & ~hit(adr_i, pdl_pkg::DEV_CTL_STAT_ADDR)
        & ~hit(adr_i, pdl_pkg::LINK_CAP_ADDR);

    a_flag_set: assert property (
        (ev_vec != 4'h0) |=> ((flag_reg & $past(ev_vec)) == $past(ev_vec))
    ) else $error("error flag not set by event");

    a_flag_w1c: assert property (
        (clr_vec != 4'h0) && (ev_vec == 4'h0) |=> ((flag_reg & $past(clr_vec)) == 4'h0)
    ) else $error("write-one did not clear flag");

    a_flag_sticky: assert property (
        (clr_vec == 4'h0) && (flag_reg != 4'h0) |=> ((flag_reg & $past(flag_reg)) == $past(flag_reg))
    ) else $error("flag dropped without a clear");

    a_set_wins: assert property (
        ((ev_vec & clr_vec) != 4'h0) |=> ((flag_reg & $past(ev_vec)) == $past(ev_vec))
    ) else $error("clear beat a same-cycle event");

    a_log_indep: assert property (
        (en_reg == 4'h0) && (ev_vec != 4'h0) |=> (flag_reg != 4'h0) && (rep_reg == 4'h0)
    ) else $error("logging depended on enables");

    a_report_gate: assert property (
        1'b1 |=> (rep_reg == ($past(ev_vec) & $past(en_reg)))
    ) else $error("report not gated by enable");

    a_aux_rst: assert property (@(posedge clk_i) disable iff (1'b0)
        $past(rst_i) |-> aux_reg && (en_reg == 4'h0) && (flag_reg == 4'h0)
    ) else $error("status reset values wrong");

    a_aux_track: assert property (
        rd_stat |-> (dat_o[pdl_pkg::AUX_PWR_BIT] == $past(aux_reg))
    ) else $error("aux bit does not follow input");

    a_aux_follow: assert property (
        !rst_i |=> (aux_reg == $past(aux_pwr_i))
    ) else $error("aux register does not track its input");

    a_stat_rsvd: assert property (
        rd_stat |-> (dat_o[31:pdl_pkg::TXN_PEND_BIT] == 11'h000)
    ) else $error("pending or reserved bits nonzero");

    a_cap_fixed: assert property (
        rd_cap |-> (dat_o[9:0] == {pdl_pkg::WIDTH_X1, pdl_pkg::SPEED_5G0})
            && (dat_o[21:19] == {~UPSTREAM, 1'b0, ~UPSTREAM}) && (dat_o[23:22] == 2'h0)
    ) else $error("fixed capability bits wrong");

    a_cap_rst: assert property (@(posedge clk_i) disable iff (1'b0)
        $past(rst_i) |-> (cap_reg == cap_default())
    ) else $error("capability reset defaults wrong");

    a_ldr_load: assert property (
        ldr_we_i |=> (cap_reg == $past(ldr_cap_i)) [*1] ##1 ($past(ldr_we_i) || $stable(cap_reg))
    ) else $error("loader override not held");

    a_ack_pulse: assert property (
        req && !ack_reg |=> ack_reg ##1 !ack_reg
    ) else $error("ack not a single cycle");

    // flags rise only on events; enables move only on a lane-0 write
    a_flag_no_ghost: assert property (
        !rst_i && (ev_vec == 4'h0) |=> ((flag_reg & ~$past(flag_reg)) == 4'h0)
    ) else $error("flag rose without an event");

    a_en_write: assert property (
        wr_take && hit(adr_i, pdl_pkg::DEV_CTL_STAT_ADDR) && sel_i[pdl_pkg::CTL_BYTE]
            |=> (en_reg == $past(dat_i[pdl_pkg::REP_EN_LSB +: 4]))
    ) else $error("enable write not taken");

    a_en_hold: assert property (
        !rst_i && !(wr_take && sel_i[pdl_pkg::CTL_BYTE]) |=> $stable(en_reg)
    ) else $error("enables changed without a write");

    // read words as the bus shows them
    a_stat_read: assert property (
        rd_stat |-> (dat_o[pdl_pkg::ERR_FLAG_LSB +: 4] == $past(flag_reg))
            && (dat_o[pdl_pkg::REP_EN_LSB +: 4] == $past(en_reg))
    ) else $error("status read does not show flags and enables");

    a_cap_read: assert property (
        rd_cap |-> (dat_o[pdl_pkg::ASPM_LSB +: 2] == $past(cap_reg.aspm))
            && (dat_o[pdl_pkg::L0S_LSB +: 3] == $past(cap_reg.l0s_lat))
            && (dat_o[pdl_pkg::L1_LSB +: 3] == $past(cap_reg.l1_lat))
            && (dat_o[pdl_pkg::CLKPM_BIT] == $past(cap_reg.clk_pm))
            && (dat_o[pdl_pkg::PORT_LSB +: 8] == $past(cap_reg.port_num))
    ) else $error("capability read does not show loaded fields");

    a_cap_sw_ro: assert property (
        !rst_i && !ldr_we_i |=> $stable(cap_reg)
    ) else $error("capability fields changed without the loader");

    a_rd_unmapped: assert property (
        rd_none |-> (dat_o == '0)
    ) else $error("unmapped read returned data");

    // handshake and reset values of the bus outputs
    a_ack_needs_req: assert property (
        !req |=> !ack_reg
    ) else $error("ack without a request");

    a_dat_hold: assert property (
        !rst_i && !(req && !ack_reg && !we_i) |=> $stable(dat_o)
    ) else $error("read data moved without a read");

    a_rst_outputs: assert property (@(posedge clk_i) disable iff (1'b0)
        $past(rst_i) |-> !ack_o && (dat_o == '0) && (err_report_o == 4'h0)
    ) else $error("bus outputs not cleared by reset");

    // ************************************************************
    // cover points
    // ************************************************************

    // main scenarios the random run should reach
    c_set_wins: cover property ((ev_vec & clr_vec) != 4'h0);
    c_w1c: cover property (clr_vec != 4'h0 ##1 flag_reg == 4'h0);
    c_cap_read: cover property (rd_cap);
    c_ldr: cover property (ldr_we_i ##2 rd_cap);
    c_report: cover property (rep_reg != 4'h0);

endmodule : pdl_regs

// [verif/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic clk_i, rst_i, cyc_i, stb_i, we_i, aux_pwr_i, ldr_we_i, ack_o, ack_d;
    logic [7:0] adr_i;
    logic [3:0] sel_i, flags, en, ev, sl;
    logic [31:0] dat_i, dat_o, dat_d, rd, rd_d, wd;
    pdl_pkg::pdl_err_t err_ev_i, err_report_o, rep_d;
    pdl_pkg::pdl_cap_t ldr_cap_i, cap_u, cap_d;
    int mismatches, checked;

    // upstream port 0 and a downstream port 2 share one bus
    pdl_regs #(.PORT_INDEX(8'h00), .UPSTREAM(1'b1)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_ev_i(err_ev_i),
        .aux_pwr_i(aux_pwr_i), .ldr_we_i(ldr_we_i), .ldr_cap_i(ldr_cap_i),
        .err_report_o(err_report_o));
    pdl_regs #(.PORT_INDEX(8'h02), .UPSTREAM(1'b0)) i_dn (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_d), .ack_o(ack_d), .err_ev_i(err_ev_i),
        .aux_pwr_i(aux_pwr_i), .ldr_we_i(ldr_we_i), .ldr_cap_i(ldr_cap_i),
        .err_report_o(rep_d));

    // ************************************************************
    // expectations and helpers
    // ************************************************************
    function logic [31:0] st();
        return {10'h000, 1'h0, aux_pwr_i, flags, 12'h000, en};
    endfunction : st

    function logic [31:0] cw(input pdl_pkg::pdl_cap_t c, input logic up);
        return {c.port_num, 2'h0, ~up, 1'h0, ~up, c.clk_pm, c.l1_lat, c.l0s_lat, c.aspm,
            6'h01, 4'h2};
    endfunction : cw

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // classic cycle; ev pulses during the ack cycle so it meets the write edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [3:0] e);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        @(posedge clk_i);
        // no cycle count assumed; only the watchdog ends a wait
        while (ack_o !== 1'b1) begin
            err_ev_i <= e;
            @(posedge clk_i);
        end
        rd = dat_o;
        // the downstream copy must answer on the same edge
        rd_d = (ack_d === 1'b1) ? dat_d : 32'hXXXXXXXX;
        err_ev_i <= 4'h0;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    task rdchk();
        wb(1'b0, 8'hC8, 32'h0, 4'h0, 4'h0);
        chk(rd, st());
        chk(rd_d, st());
        wb(1'b0, 8'hCC, 32'h0, 4'h0, 4'h0);
        chk(rd, cw(cap_u, 1'b1));
        chk(rd_d, cw(cap_d, 1'b0));
    endtask : rdchk

    // reset may land mid-run, so the models restart too
    task rchk();
        flags = 4'h0;
        en = 4'h0;
        cap_u = '{8'h00, 1'b1, 3'h5, 3'h3, 2'h3};
        cap_d = '{8'h02, 1'b0, 3'h5, 3'h3, 2'h3};
        aux_pwr_i <= 1'b1;
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk();
    endtask : rchk

    task conclude();
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // ************************************************************
    // clock, watchdog and main sequence
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // run needs well under a thousand cycles; this is far beyond that
    initial begin
        #100us;
        mismatches++;
        conclude();
    end

    initial begin
        {cyc_i, stb_i, we_i, ldr_we_i} <= 4'h0;
        {adr_i, sel_i, dat_i} <= 44'h0;
        err_ev_i <= 4'h0;
        ldr_cap_i <= 17'h0;
        void'($urandom(48852));
        rchk();
        // set wins over a full clear, then clear, then ignored writes
        wb(1'b1, 8'hC8, 32'hFFFFFFFF, 4'hF, 4'hF);
        en = 4'hF;
        flags = 4'hF;
        rdchk();
        wb(1'b1, 8'hC8, 32'hFFFFFFFF, 4'h4, 4'h0);
        flags = 4'h0;
        wb(1'b1, 8'hCC, 32'h0, 4'hF, 4'h0);
        wb(1'b1, 8'hD4, 32'h0, 4'hF, 4'h0);
        wb(1'b0, 8'hD4, 32'h0, 4'h0, 4'h0);
        chk(rd, 32'h0);
        chk(rd_d, 32'h0);
        rdchk();
        repeat (60) begin
            ev = 4'($urandom());
            aux_pwr_i <= 1'($urandom());
            case ($urandom_range(2))
                0: begin
                    wd = $urandom();
                    sl = 4'($urandom());
                    wb(1'b1, 8'hC8, wd, sl, ev);
                    if (sl[0]) begin
                        en = wd[3:0];
                    end
                    flags = (flags & ~(sl[2] ? wd[19:16] : 4'h0)) | ev;
                end
                1: begin
                    @(posedge clk_i);
                    err_ev_i <= ev;
                    @(posedge clk_i);
                    err_ev_i <= 4'h0;
                    @(posedge clk_i);
                    chk({28'h0, err_report_o}, {28'h0, ev & en});
                    chk({28'h0, rep_d}, {28'h0, ev & en});
                    flags = flags | ev;
                end
                default: begin
                    cap_u = pdl_pkg::pdl_cap_t'(17'($urandom()));
                    cap_d = cap_u;
                    @(posedge clk_i);
                    ldr_cap_i <= cap_u;
                    ldr_we_i <= 1'b1;
                    @(posedge clk_i);
                    ldr_we_i <= 1'b0;
                end
            endcase
            rdchk();
        end
        rchk();
        conclude();
    end

endmodule : tb_top
